//--- rtl/hsr_reporter.sv
// Command interpreter and status builder of the field-protocol add-on.
// Assumes framing is done outside; one command arrives per strobe and the
// meter link master performs one register read per request.
`timescale 1ns/1ps
//
// Operation
// - Serve universal 0,1,2,3,6,7,8,9,11-22,38,48 and device-specific only.
// - Command 9 exposes variables 0 to 12 with their classifications.
// - Command 3 maps flow rate and the three totals as dynamic variables.
// - Unsupported device status bits, non-primary range among them, read zero.
// - Status bit 0 follows primary variable beyond sensor limits.
// - Status bit 2 set while loop current would pass 4 or 20 mA.
// - Status bit 3 set with non-zero poll address; loop held at 4 mA.
// - Status bit 4 set on any alarm or failure.
// - Status bit 5 set at power-up and on meter reset.
// - Status bit 6 set on configuration change, cleared by command 38.
// - Status bit 7 set when a failure prevents flow measurement.
// - Meter error word polled periodically; commands 9 and 48 use it.
// - Meter error word bits 0 to 8 meaningful; others read zero.
// - Command 0 reply carries extended status in byte 16.
// - Extended bit 0 set for meter bits 0,1,3,4,7,8.
// - Extended bit 1 set for meter bits 2,5,6.
// - Variable status is c0 for good data, 00 for bad.
// - Command 48 byte 4 bit 0 flags a failed meter link.
// - Reply only to a master request; never transmit unprompted.
module hsr_reporter #(
  parameter int unsigned POLL_CYCLES = hsr_pkg::POLL_CYCLES,
  parameter int unsigned LINK_TIMEOUT_CYCLES = hsr_pkg::LINK_TIMEOUT_CYCLES
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic cmd_valid_i,
  input wire logic [7:0] cmd_num_i,
  input wire logic [7:0] cmd_arg_i,
  input wire logic pv_over_limit_i,
  input wire logic loop_saturated_i,
  input wire logic meter_reset_i,
  input wire logic meter_cfg_changed_i,
  input wire logic link_done_i,
  input wire logic link_ok_i,
  input wire logic [15:0] link_data_i,
  output logic rsp_valid_o,
  output logic [7:0] rsp_code_o,
  output logic [7:0] rsp_dev_status_o,
  output logic [7:0] rsp_ext_status_o,
  output logic [63:0] rsp_data_o,
  output logic link_req_o,
  output logic fixed_current_o,
  output logic [7:0] poll_addr_o,
  output logic [15:0] meter_error_status_o
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic cmd_supported(input logic [7:0] c);
    cmd_supported = (c <= hsr_pkg::CMD_READ_DYN) || (c >= hsr_pkg::CMD_WRITE_POLL && c <= hsr_pkg::CMD_READ_VARS)
      || (c >= hsr_pkg::CMD_FIRST_RANGE && c <= hsr_pkg::CMD_LAST_RANGE)
      || (c == hsr_pkg::CMD_RESET_CFG) || (c == hsr_pkg::CMD_MORE_STATUS)
      || (c >= hsr_pkg::CMD_DEV_FIRST && c <= hsr_pkg::CMD_DEV_LAST);
  endfunction

  function automatic logic [7:0] var_class(input logic [7:0] idx);
    case (idx)
      8'h00, 8'h06: var_class = 8'h42;
      8'h01: var_class = 8'h43;
      8'h05: var_class = 8'h51;
      8'h0c: var_class = 8'h46;
      default: var_class = 8'h44;
    endcase
  endfunction

  function automatic logic cmd_writes_cfg(input logic [7:0] c);
    cmd_writes_cfg = (c == hsr_pkg::CMD_WRITE_POLL) || (c == hsr_pkg::CMD_WRITE_MSG)
      || (c == hsr_pkg::CMD_WRITE_TAG) || (c == hsr_pkg::CMD_WRITE_ASM) || (c == hsr_pkg::CMD_WRITE_LTAG);
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  hsr_pkg::hsr_poll_t poll_state;
  hsr_pkg::hsr_poll_t next_poll_state;
  logic [31:0] poll_cnt;
  logic [31:0] wait_cnt;
  logic [15:0] meter_error_status;
  logic comm_fail;
  logic [7:0] poll_addr;
  logic reset_flag;
  logic cfg_changed;

  // ----------------------------------------
  // Status mapping
  // ----------------------------------------
  logic [7:0] ext_status;
  logic [63:0] more_status;
  logic any_alarm;
  logic malfunction;

  hsr_status_map u_map (
    .meter_error_status_i(meter_error_status),
    .comm_fail_i(comm_fail),
    .ext_status_o(ext_status),
    .more_status_o(more_status),
    .any_alarm_o(any_alarm),
    .malfunction_o(malfunction)
  );

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  wire cmd_take = ce_i && cmd_valid_i;
  wire cmd_ok = cmd_supported(cmd_num_i);
  wire cmd_is_vars = cmd_num_i == hsr_pkg::CMD_READ_VARS;
  wire var_bad = cmd_is_vars && (cmd_arg_i > hsr_pkg::LAST_VAR);
  wire cmd_done = cmd_take && cmd_ok && !var_bad;
  wire clr_cfg = cmd_done && (cmd_num_i == hsr_pkg::CMD_RESET_CFG);
  wire set_cfg = meter_cfg_changed_i || (cmd_done && cmd_writes_cfg(cmd_num_i));
  wire poll_write = cmd_done && (cmd_num_i == hsr_pkg::CMD_WRITE_POLL);
  wire [7:0] var_status = malfunction ? hsr_pkg::VS_BAD : hsr_pkg::VS_GOOD;

  logic [7:0] dev_status;
  always_comb begin
    dev_status = 8'h00;
    dev_status[hsr_pkg::DS_PV_RANGE] = pv_over_limit_i;
    dev_status[hsr_pkg::DS_PV_SAT] = loop_saturated_i;
    dev_status[hsr_pkg::DS_PV_FIXED] = poll_addr != 8'h00;
    dev_status[hsr_pkg::DS_MORE] = any_alarm;
    dev_status[hsr_pkg::DS_RESET] = reset_flag;
    dev_status[hsr_pkg::DS_CFG_CHG] = cfg_changed;
    dev_status[hsr_pkg::DS_MALF] = malfunction;
  end

  logic [7:0] next_code;
  logic [63:0] next_data;
  always_comb begin
    next_code = hsr_pkg::RC_OK;
    next_data = 64'h0;
    if (!cmd_ok) begin
      next_code = hsr_pkg::RC_NOT_IMPL;
    end else if (var_bad) begin
      next_code = hsr_pkg::RC_BAD_SELECT;
    end else begin
      case (cmd_num_i)
        hsr_pkg::CMD_READ_PV: begin
          next_data[7:0] = hsr_pkg::DV_PRIMARY;
        end
        hsr_pkg::CMD_READ_DYN: begin
          next_data[31:0] = {hsr_pkg::DV_FOURTH, hsr_pkg::DV_TERTIARY,
                             hsr_pkg::DV_SECONDARY, hsr_pkg::DV_PRIMARY};
        end
        hsr_pkg::CMD_WRITE_POLL: begin
          next_data[7:0] = cmd_arg_i;
        end
        hsr_pkg::CMD_READ_VARS: begin
          next_data[23:0] = {var_status, var_class(cmd_arg_i), cmd_arg_i};
        end
        hsr_pkg::CMD_MORE_STATUS: begin
          next_data = more_status;
        end
        default: begin
          next_data = 64'h0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Reply registers
  // ----------------------------------------
  // Reply only ever follows a taken command, one cycle later
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      rsp_valid_o <= 1'b0;
      rsp_code_o <= hsr_pkg::RC_OK;
      rsp_data_o <= 64'h0;
      rsp_ext_status_o <= 8'h00;
    end else if (ce_i) begin
      rsp_valid_o <= cmd_valid_i;
      if (cmd_valid_i) begin
        rsp_code_o <= next_code;
        rsp_data_o <= next_data;
        rsp_ext_status_o <= ext_status;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      rsp_dev_status_o <= 8'h00;
    end else if (ce_i) begin
      rsp_dev_status_o <= dev_status;
    end
  end

  // ----------------------------------------
  // Sticky flags and poll address
  // ----------------------------------------
  // Reset flag is cleared once it has gone out in a successful reply; a new reset wins
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      reset_flag <= 1'b1;
      cfg_changed <= 1'b0;
    end else if (ce_i) begin
      if (meter_reset_i) begin
        reset_flag <= 1'b1;
      end else if (cmd_done) begin
        reset_flag <= 1'b0;
      end
      if (set_cfg) begin
        cfg_changed <= 1'b1;
      end else if (clr_cfg) begin
        cfg_changed <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      poll_addr <= hsr_pkg::POLL_ADDR_RST;
      poll_addr_o <= hsr_pkg::POLL_ADDR_RST;
      fixed_current_o <= 1'b0;
    end else if (ce_i) begin
      if (poll_write) begin
        poll_addr <= cmd_arg_i;
      end
      poll_addr_o <= poll_addr;
      fixed_current_o <= poll_addr != 8'h00;
    end
  end

  // ----------------------------------------
  // Meter link poller
  // ----------------------------------------
  wire poll_due = poll_cnt >= POLL_CYCLES - 1;
  wire wait_over = wait_cnt >= LINK_TIMEOUT_CYCLES - 1;

  always_comb begin
    case (poll_state)
      hsr_pkg::HSR_IDLE: next_poll_state = poll_due ? hsr_pkg::HSR_REQ : hsr_pkg::HSR_IDLE;
      hsr_pkg::HSR_REQ: next_poll_state = hsr_pkg::HSR_WAIT;
      hsr_pkg::HSR_WAIT: next_poll_state = (link_done_i || wait_over) ? hsr_pkg::HSR_IDLE : hsr_pkg::HSR_WAIT;
      default: next_poll_state = hsr_pkg::HSR_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      poll_state <= hsr_pkg::HSR_IDLE;
      poll_cnt <= 32'h0;
      wait_cnt <= 32'h0;
      link_req_o <= 1'b0;
    end else if (ce_i) begin
      poll_state <= next_poll_state;
      poll_cnt <= (poll_state == hsr_pkg::HSR_IDLE && !poll_due) ? poll_cnt + 32'h1 : 32'h0;
      wait_cnt <= (poll_state == hsr_pkg::HSR_WAIT) ? wait_cnt + 32'h1 : 32'h0;
      link_req_o <= next_poll_state == hsr_pkg::HSR_REQ;
    end
  end

  // Failed or silent link keeps the last word but flags the failure
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      meter_error_status <= hsr_pkg::MES_RST;
      meter_error_status_o <= hsr_pkg::MES_RST;
      comm_fail <= 1'b0;
    end else if (ce_i) begin
      if (poll_state == hsr_pkg::HSR_WAIT && link_done_i) begin
        comm_fail <= !link_ok_i;
        if (link_ok_i) begin
          meter_error_status <= link_data_i & hsr_pkg::MES_USED_MASK;
        end
      end else if (poll_state == hsr_pkg::HSR_WAIT && wait_over) begin
        comm_fail <= 1'b1;
      end
      meter_error_status_o <= meter_error_status;
    end
  end
endmodule

//--- rtl/hsr_pkg.sv
// Shared constants for the flowmeter field-protocol status reporter.
// Assumes one 40 MHz core clock and a synchronous, active-high reset.
package hsr_pkg;
  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned POLL_PERIOD_MS = 100;
  localparam int unsigned POLL_CYCLES = POLL_PERIOD_MS * (CLK_HZ / 1000);
  localparam int unsigned LINK_TIMEOUT_MS = 50;
  localparam int unsigned LINK_TIMEOUT_CYCLES = LINK_TIMEOUT_MS * (CLK_HZ / 1000);

  // ----------------------------------------
  // Universal and device-specific command numbers
  // ----------------------------------------
  localparam logic [7:0] CMD_READ_ID = 8'h00;
  localparam logic [7:0] CMD_READ_PV = 8'h01;
  localparam logic [7:0] CMD_READ_DYN = 8'h03;
  localparam logic [7:0] CMD_WRITE_POLL = 8'h06;
  localparam logic [7:0] CMD_READ_VARS = 8'h09;
  localparam logic [7:0] CMD_FIRST_RANGE = 8'h0b;
  localparam logic [7:0] CMD_LAST_RANGE = 8'h16;
  localparam logic [7:0] CMD_RESET_CFG = 8'h26;
  localparam logic [7:0] CMD_MORE_STATUS = 8'h30;
  localparam logic [7:0] CMD_WRITE_MSG = 8'h11;
  localparam logic [7:0] CMD_WRITE_TAG = 8'h12;
  localparam logic [7:0] CMD_WRITE_ASM = 8'h13;
  localparam logic [7:0] CMD_WRITE_LTAG = 8'h16;
  localparam logic [7:0] CMD_DEV_FIRST = 8'h80;
  localparam logic [7:0] CMD_DEV_LAST = 8'hfd;

  // ----------------------------------------
  // Response codes
  // ----------------------------------------
  localparam logic [7:0] RC_OK = 8'h00;
  localparam logic [7:0] RC_BAD_SELECT = 8'h02;
  localparam logic [7:0] RC_NOT_IMPL = 8'h40;

  // ----------------------------------------
  // Device status byte positions
  // ----------------------------------------
  localparam int unsigned DS_PV_RANGE = 0;
  localparam int unsigned DS_PV_SAT = 2;
  localparam int unsigned DS_PV_FIXED = 3;
  localparam int unsigned DS_MORE = 4;
  localparam int unsigned DS_RESET = 5;
  localparam int unsigned DS_CFG_CHG = 6;
  localparam int unsigned DS_MALF = 7;

  // ----------------------------------------
  // Meter error status and derived fields
  // ----------------------------------------
  localparam logic [15:0] MES_USED_MASK = 16'h01ff;
  localparam logic [15:0] MES_MAINT_MASK = 16'h019b;
  localparam logic [15:0] MES_ALERT_MASK = 16'h0064;
  localparam logic [15:0] MES_ERROR_MASK = 16'h018b;
  localparam int unsigned EXT_MAINT = 0;
  localparam int unsigned EXT_ALERT = 1;
  localparam int unsigned B48_COMM_FAIL = 32;
  localparam logic [7:0] VS_GOOD = 8'hc0;
  localparam logic [7:0] VS_BAD = 8'h00;
  localparam logic [7:0] LAST_VAR = 8'h0c;

  // ----------------------------------------
  // Dynamic variable assignment (device variable numbers)
  // ----------------------------------------
  localparam logic [7:0] DV_PRIMARY = 8'h00;
  localparam logic [7:0] DV_SECONDARY = 8'h02;
  localparam logic [7:0] DV_TERTIARY = 8'h03;
  localparam logic [7:0] DV_FOURTH = 8'h04;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] POLL_ADDR_RST = 8'h00;
  localparam logic [15:0] MES_RST = 16'h0000;

  typedef enum logic [2:0] {
    HSR_IDLE = 3'b001,
    HSR_REQ = 3'b010,
    HSR_WAIT = 3'b100
  } hsr_poll_t;
endpackage

//--- rtl/hsr_status_map.sv
// Maps the polled meter error word onto reported status fields.
// Purely combinational; the caller registers every result.
`timescale 1ns/1ps
module hsr_status_map (
  input wire logic [15:0] meter_error_status_i,
  input wire logic comm_fail_i,
  output logic [7:0] ext_status_o,
  output logic [63:0] more_status_o,
  output logic any_alarm_o,
  output logic malfunction_o
);
  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire [15:0] used = meter_error_status_i & hsr_pkg::MES_USED_MASK;
  wire maint = |(used & hsr_pkg::MES_MAINT_MASK);
  wire alert = |(used & hsr_pkg::MES_ALERT_MASK);

  always_comb begin
    ext_status_o = 8'h00;
    ext_status_o[hsr_pkg::EXT_MAINT] = maint;
    ext_status_o[hsr_pkg::EXT_ALERT] = alert;
    more_status_o = 64'h0;
    more_status_o[15:0] = used;
    more_status_o[hsr_pkg::B48_COMM_FAIL] = comm_fail_i;
  end

  // Lost link counts as a failure: the meter values are stale
  assign any_alarm_o = (|used) | comm_fail_i;
  assign malfunction_o = (|(used & hsr_pkg::MES_ERROR_MASK)) | comm_fail_i;
endmodule

//--- tb/hsr_checker.sv
// Port checker for the status reporter.
// Assumes ce_i is held high.
`timescale 1ns/1ps
module hsr_checker #(
  parameter int unsigned POLL_CYCLES = 20,
  parameter int unsigned LINK_TIMEOUT_CYCLES = 10
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic cmd_valid_i,
  input wire logic [7:0] cmd_num_i,
  input wire logic [7:0] cmd_arg_i,
  input wire logic pv_over_limit_i,
  input wire logic loop_saturated_i,
  input wire logic meter_cfg_changed_i,
  input wire logic rsp_valid_o,
  input wire logic [7:0] rsp_code_o,
  input wire logic [7:0] rsp_dev_status_o,
  input wire logic [63:0] rsp_data_o,
  input wire logic link_req_o,
  input wire logic fixed_current_o,
  input wire logic [7:0] poll_addr_o,
  input wire logic [15:0] meter_error_status_o
);
  // ----
  // Helpers
  // ----
  wire logic [7:0] n;
  wire logic supp;
  logic [31:0] idle_cnt;
  assign n = cmd_num_i;
  assign supp = n <= 8'h03 || (n >= 8'h06 && n <= 8'h09) || (n >= 8'h0b && n <= 8'h16) || n == 8'h26
    || n == 8'h30 || (n >= 8'h80 && n <= 8'hfd);
  // Counter, since a poll period is far beyond a repetition count
  always_ff @(posedge core_clk_i) begin
    if (reset_i || link_req_o) begin
      idle_cnt <= '0;
    end else begin
      idle_cnt <= idle_cnt + 32'h1;
    end
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  // ----
  // Assertions
  // ----
  a_reply_next: assert property (cmd_valid_i |=> rsp_valid_o) else $error("no reply");
  a_no_unprompted: assert property (rsp_valid_o |-> $past(cmd_valid_i)) else $error("unprompted reply");
  a_not_impl: assert property (cmd_valid_i && !supp |=> rsp_code_o == 8'h40 && rsp_data_o == 64'h0)
    else $error("bad not-implemented reply");
  a_bad_index: assert property (cmd_valid_i && n == 8'h09 && cmd_arg_i > 8'h0c |=> rsp_code_o == 8'h02)
    else $error("bad index accepted");
  a_bit1_zero: assert property (!rsp_dev_status_o[1]) else $error("status bit 1 set");
  a_pv_range: assert property (rsp_dev_status_o[0] == $past(pv_over_limit_i)) else $error("bit 0 wrong");
  a_pv_sat: assert property (rsp_dev_status_o[2] == $past(loop_saturated_i)) else $error("bit 2 wrong");
  a_fixed_addr: assert property (fixed_current_o == (poll_addr_o != 8'h00)) else $error("fixed wrong");
  a_cfg_set: assert property (meter_cfg_changed_i |=> ##[1:2] rsp_dev_status_o[6]) else $error("no bit 6");
  a_cfg_clear: assert property (cmd_valid_i && n == 8'h26 && !meter_cfg_changed_i |=> ##[1:2]
    !rsp_dev_status_o[6]) else $error("bit 6 kept");
  a_reset_flag: assert property ($fell(reset_i) |-> ##[1:2] rsp_dev_status_o[5]) else $error("no bit 5");
  a_poll_gap: assert property (link_req_o |=> !link_req_o [*8]) else $error("polls too close");
  a_poll_due: assert property (idle_cnt <= POLL_CYCLES + LINK_TIMEOUT_CYCLES + 4) else $error("poll late");
  a_word_mask: assert property (meter_error_status_o[15:9] == 7'h00) else $error("high bits set");
  c_more: cover property (cmd_valid_i && n == 8'h30 ##1 rsp_valid_o);
  c_bad_sel: cover property (rsp_valid_o && rsp_code_o == 8'h02);
  c_poll: cover property (link_req_o);
endmodule
bind hsr_reporter hsr_checker #(.POLL_CYCLES(POLL_CYCLES), .LINK_TIMEOUT_CYCLES(LINK_TIMEOUT_CYCLES)) u_chk (
  .core_clk_i(core_clk_i), .reset_i(reset_i), .cmd_valid_i(cmd_valid_i), .cmd_num_i(cmd_num_i),
  .cmd_arg_i(cmd_arg_i), .pv_over_limit_i(pv_over_limit_i), .loop_saturated_i(loop_saturated_i),
  .meter_cfg_changed_i(meter_cfg_changed_i), .rsp_valid_o(rsp_valid_o), .rsp_code_o(rsp_code_o),
  .rsp_dev_status_o(rsp_dev_status_o), .rsp_data_o(rsp_data_o), .link_req_o(link_req_o),
  .fixed_current_o(fixed_current_o), .poll_addr_o(poll_addr_o), .meter_error_status_o(meter_error_status_o));

//--- tb/hsr_meter_model.sv
// Behavioural meter link responder.
// Answers each read request delay_i + 1 cycles after it; a new request restarts it.
`timescale 1ns/1ps
module hsr_meter_model (
  input wire logic core_clk_i,
  input wire logic link_req_i,
  input wire logic [7:0] delay_i,
  input wire logic ok_i,
  input wire logic [15:0] word_i,
  output logic link_done_o,
  output logic link_ok_o,
  output logic [15:0] link_data_o
);
  // ----
  // Responder
  // ----
  logic [7:0] cnt = 8'h00;
  logic busy = 1'b0;
  initial begin
    link_done_o = 1'b0;
    link_ok_o = 1'b0;
    link_data_o = 16'h0000;
  end
  // Idle lines toggle so stale values never look valid
  always @(posedge core_clk_i) begin
    link_done_o <= 1'b0;
    link_ok_o <= ~link_ok_o;
    link_data_o <= ~link_data_o;
    if (link_req_i) begin
      busy <= 1'b1;
      cnt <= delay_i;
    end else if (busy && cnt != 8'h00) begin
      cnt <= cnt - 8'h01;
    end else if (busy) begin
      busy <= 1'b0;
      link_done_o <= 1'b1;
      link_ok_o <= ok_i;
      link_data_o <= word_i;
    end
  end
endmodule

//--- tb/hsr_reporter_bench.sv
// Self-checking bench for the status reporter.
// Assumes the meter model on the link; clock enable held high.
`timescale 1ns/1ps
module hsr_reporter_bench;
  logic core_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic cmd_valid_i = 1'b0;
  logic [7:0] cmd_num_i = 8'h00;
  logic [7:0] cmd_arg_i = 8'h00;
  logic pv_over_limit_i = 1'b0;
  logic loop_saturated_i = 1'b0;
  logic meter_reset_i = 1'b0;
  logic meter_cfg_changed_i = 1'b0;
  logic [7:0] delay = 8'h03;
  logic ok = 1'b1;
  logic [15:0] word = 16'h0000;
  logic link_done_i, link_ok_i, rsp_valid_o, link_req_o, fixed_current_o;
  logic [15:0] link_data_i, meter_error_status_o, w;
  logic [7:0] rsp_code_o, rsp_dev_status_o, rsp_ext_status_o, poll_addr_o;
  logic [63:0] rsp_data_o;
  int seed = 55451;
  int err_total = 0;
  int samples_checked = 0;
  int i;
  always #12.5 core_clk_i = ~core_clk_i;
  // Short poll and timeout keep the run small
  hsr_reporter #(.POLL_CYCLES(20), .LINK_TIMEOUT_CYCLES(10)) u_dut (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .ce_i(1'b1), .cmd_valid_i(cmd_valid_i), .cmd_num_i(cmd_num_i), .cmd_arg_i(cmd_arg_i),
    .pv_over_limit_i(pv_over_limit_i), .loop_saturated_i(loop_saturated_i), .meter_reset_i(meter_reset_i),
    .meter_cfg_changed_i(meter_cfg_changed_i), .link_done_i(link_done_i), .link_ok_i(link_ok_i),
    .link_data_i(link_data_i), .rsp_valid_o(rsp_valid_o), .rsp_code_o(rsp_code_o),
    .rsp_dev_status_o(rsp_dev_status_o), .rsp_ext_status_o(rsp_ext_status_o), .rsp_data_o(rsp_data_o),
    .link_req_o(link_req_o), .fixed_current_o(fixed_current_o), .poll_addr_o(poll_addr_o),
    .meter_error_status_o(meter_error_status_o));
  hsr_meter_model u_meter (.core_clk_i(core_clk_i), .link_req_i(link_req_o), .delay_i(delay), .ok_i(ok),
    .word_i(word), .link_done_o(link_done_i), .link_ok_o(link_ok_i), .link_data_o(link_data_i));
  // ----
  // Tasks and expectations
  // ----
  task automatic end_sim();
    $display("Counts: mismatches %0d, checks %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      err_total++;
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk_i);
    #2;
  endtask
  task automatic send(input logic [7:0] num, input logic [7:0] arg);
    int k;
    cmd_num_i = num;
    cmd_arg_i = arg;
    cmd_valid_i = 1'b1;
    tick(1);
    cmd_valid_i = 1'b0;
    for (k = 0; k < 3 && rsp_valid_o !== 1'b1; k++) tick(1);
    if (k == 3) begin
      err_total++;
      end_sim();
    end
    tick(1);
  endtask
  task automatic wait_sig(input bit req);
    int k;
    for (k = 0; k < 200 && (req ? link_req_o : link_done_i) !== 1'b1; k++) tick(1);
    if (k == 200) begin
      err_total++;
      end_sim();
    end
    tick(req ? 14 : 3);
  endtask
  function automatic logic [7:0] exp_code(input logic [7:0] n, input logic [7:0] a);
    if (n == 8'h09 && a > 8'h0c) return 8'h02;
    if (n <= 8'h03 || (n >= 8'h06 && n <= 8'h09) || (n >= 8'h0b && n <= 8'h16)) return 8'h00;
    if (n == 8'h26 || n == 8'h30 || (n >= 8'h80 && n <= 8'hfd)) return 8'h00;
    return 8'h40;
  endfunction
  function automatic logic [7:0] exp_cls(input logic [7:0] x);
    return (x == 0 || x == 6) ? 8'h42 : (x == 1) ? 8'h43 : (x == 5) ? 8'h51 : (x == 12) ? 8'h46 : 8'h44;
  endfunction
  // Checks replies that depend on the meter word and link state
  task automatic chk_status(input logic [15:0] v, input logic fail);
    send(8'h30, 8'h00);
    chk(rsp_data_o[15:0], v & 16'h01ff);
    chk(rsp_data_o[32], fail);
    send(8'h00, 8'h00);
    chk(rsp_ext_status_o, {6'h00, |(v & 16'h0064), |(v & 16'h019b)});
    chk({rsp_dev_status_o[7], rsp_dev_status_o[4]}, {|(v & 16'h018b) | fail, |v[8:0] | fail});
    send(8'h09, 8'h00);
    chk(rsp_data_o[23:16], (fail || |(v & 16'h018b)) ? 8'h00 : 8'hc0);
  endtask
  // ----
  // Scenarios
  // ----
  initial begin
    tick(12);
    reset_i = 1'b0;
    tick(3);
    chk(rsp_dev_status_o[5], 1'b1);
    chk(poll_addr_o, 8'h00);
    $display("test reset done");
    for (i = 0; i < 256; i++) begin
      send(8'(i), (i == 6) ? 8'h00 : 8'($random(seed) & 15));
      chk(rsp_code_o, exp_code(8'(i), cmd_arg_i));
      if (rsp_code_o !== 8'h00) chk(rsp_data_o, 64'h0);
      if (i == 3) chk(rsp_data_o[31:0], 32'h04030200);
      if (i == 9 && cmd_arg_i <= 8'h0c) chk(rsp_data_o[23:0], {8'hc0, exp_cls(cmd_arg_i), cmd_arg_i});
    end
    $display("test command sweep done");
    send(8'h26, 8'h00);
    tick(2);
    chk(rsp_dev_status_o[6], 1'b0);
    meter_cfg_changed_i = 1'b1;
    tick(1);
    meter_cfg_changed_i = 1'b0;
    send(8'h04, 8'h00);
    chk(rsp_dev_status_o[6], 1'b1);
    send(8'h26, 8'h00);
    tick(2);
    chk(rsp_dev_status_o[6], 1'b0);
    meter_reset_i = 1'b1;
    tick(1);
    meter_reset_i = 1'b0;
    tick(2);
    chk(rsp_dev_status_o[5], 1'b1);
    send(8'h01, 8'h00);
    chk(rsp_data_o[7:0], 8'h00);
    tick(2);
    chk(rsp_dev_status_o[5], 1'b0);
    $display("test flags done");
    for (i = 0; i < 8; i++) begin
      pv_over_limit_i = 1'($random(seed));
      loop_saturated_i = 1'($random(seed));
      tick(2);
      chk({rsp_dev_status_o[2], rsp_dev_status_o[0]}, {loop_saturated_i, pv_over_limit_i});
    end
    send(8'h06, 8'h05);
    tick(2);
    chk({fixed_current_o, poll_addr_o, rsp_dev_status_o[3]}, {1'b1, 8'h05, 1'b1});
    send(8'h06, 8'h00);
    tick(2);
    chk({fixed_current_o, rsp_dev_status_o[3]}, 2'b00);
    $display("test levels done");
    for (i = 0; i < 8; i++) begin
      w = (i == 0) ? 16'hffff : (i == 1) ? 16'h0064 : (i == 2) ? 16'h0010 : 16'($random(seed));
      word = w;
      wait_sig(1'b0);
      chk(meter_error_status_o, w & 16'h01ff);
      chk_status(w, 1'b0);
    end
    word = 16'h0000;
    // Land a clean zero word first: a failed link keeps the stale one
    wait_sig(1'b0);
    chk(meter_error_status_o, 16'h0000);
    for (i = 0; i < 2; i++) begin
      delay = (i == 0) ? 8'h1e : 8'h03;
      ok = (i != 0) ? 1'b0 : 1'b1;
      wait_sig(1'b1);
      wait_sig(1'b1);
      chk_status(16'h0000, 1'b1);
    end
    delay = 8'h03;
    ok = 1'b1;
    wait_sig(1'b0);
    chk_status(16'h0000, 1'b0);
    $display("test link done");
    end_sim();
  end
endmodule
